// *** hw/i2c_stophold_busdetect.sv ***
/*
  Stop-mode holdoff, START/STOP detection and interrupt flag logic of an
  I2C controller, with an APB register slave.
  Assumes the transfer engine runs on mclk and reports its state here;
  scl and sda come raw from the pins and are synchronised inside.
*/
// Function
// - busy holdoff: finish byte and ack first
// - holdoff with idle or disabled: ack at once
// - holdoff off: never delay stop entry
// - transfer-complete interrupt survives stop mode
// - stop flag bit 6, write one clears
// - stop flag only for matched slave
// - start flag bit 4, write one clears
// - bit 5 gates start/stop interrupt
// - irq flag reasserts while condition flag set
// - reserved bits read zero, ignore writes
module i2c_stophold_busdetect (
  input wire logic mclk,
  input wire logic srst,
  input wire stophold_pkg::apb_req_type apb_req,
  output logic [stophold_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic transfer_active,
  input wire logic byte_done,
  input wire logic slave_matched,
  input wire logic master_active,
  input wire logic transfer_complete_flag,
  input wire logic stop_req,
  output logic stop_ack,
  output logic irq
);
  import stophold_pkg::*;

  // ==========================================================
  // pin synchronisers and condition detect
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic start_det, stop_det;

  // two flops before use; the prev flops only see the second stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // sda moving while scl stays high marks a bus condition
  assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  // ==========================================================
  // apb decode
  logic wr_en, setup_rd;
  logic hit_scs, hit_ctrl, hit_stat, hit_mask, hit_any;
  logic [7:0] wbyte;

  assign hit_scs = apb_req.paddr == SCS_ADDR;
  assign hit_ctrl = apb_req.paddr == CTRL_ADDR;
  assign hit_stat = apb_req.paddr == IRQ_STAT_ADDR;
  assign hit_mask = apb_req.paddr == IRQ_MASK_ADDR;
  assign hit_any = hit_scs | hit_ctrl | hit_stat | hit_mask;
  // byte lane 0 only; other lanes hold nothing
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_req.pstrb[0];
  assign setup_rd = apb_req.psel & ~apb_req.penable;
  assign wbyte = apb_req.pwdata[7:0];

  // zero wait states; read data was captured in the setup cycle
  assign pready = apb_req.psel & apb_req.penable;
  assign pslverr = pready & ~hit_any;

  // ==========================================================
  // holdoff state machine
  typedef enum logic [1:0] {RUN, WAIT_BYTE, ACKED} hold_state_type;
  hold_state_type state_reg, state_next;
  scs_type scs_reg, scs_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic mod_en, mod_ie;

  assign mod_ie = ctrl_reg[MOD_IE_BIT];
  assign mod_en = ctrl_reg[MOD_EN_BIT];

  // a busy bus with holdoff on and the module enabled defers the ack to the byte end
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RUN: begin
        if (stop_req) begin
          if (scs_reg.hold_en && transfer_active && mod_en) begin
            state_next = WAIT_BYTE;
          end else begin
            state_next = ACKED;
          end
        end
      end
      WAIT_BYTE: begin
        if (!stop_req) begin
          state_next = RUN;
        end else if (byte_done) begin
          state_next = ACKED;
        end
      end
      ACKED: begin
        if (!stop_req) begin
          state_next = RUN;
        end
      end
      default: state_next = RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // level ack, held for as long as the request stands
  assign stop_ack = state_reg == ACKED;

  // ==========================================================
  // stop-control/status and control registers
  always_comb begin
    scs_next = scs_reg;
    ctrl_next = ctrl_reg;
    // write one clears first so a same-cycle detect wins below
    if (wr_en && hit_scs) begin
      scs_next.hold_en = wbyte[HOLD_EN_BIT];
      scs_next.cond_ie = wbyte[COND_IE_BIT];
      if (wbyte[STOP_FLAG_BIT]) begin
        scs_next.stop_flag = 1'b0;
      end
      if (wbyte[START_FLAG_BIT]) begin
        scs_next.start_flag = 1'b0;
      end
    end
    if (stop_det && slave_matched && !master_active) begin
      scs_next.stop_flag = 1'b1;
    end
    if (start_det) begin
      scs_next.start_flag = 1'b1;
    end
    scs_next.rsvd = 4'h0;
    if (wr_en && hit_ctrl) begin
      ctrl_next = wbyte[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      scs_reg <= SCS_RESET;
      ctrl_reg <= CTRL_RESET;
    end else begin
      scs_reg <= scs_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================================
  // interrupt status and mask
  logic [1:0] irq_stat_reg, irq_stat_next;
  logic [1:0] irq_mask_reg, irq_mask_next;
  logic tcf_prev_reg, tcf_prev_next;
  logic ack_prev_reg, ack_prev_next;
  logic cond_set, tcf_set;

  // level set from the flags, so clearing the irq flag early does
  // not stick while a condition flag is still pending
  assign cond_set = scs_reg.cond_ie & (scs_reg.start_flag | scs_reg.stop_flag);
  // the sticky flag keeps a completion across stop mode
  assign tcf_set = mod_ie & transfer_complete_flag & ~tcf_prev_reg;

  always_comb begin
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    tcf_prev_next = transfer_complete_flag;
    ack_prev_next = stop_ack;
    if (wr_en && hit_stat) begin
      irq_stat_next = irq_stat_reg & ~wbyte[1:0];
    end
    if (cond_set || tcf_set) begin
      irq_stat_next[IRQ_FLAG_BIT] = 1'b1;
    end
    if (stop_ack && !ack_prev_reg) begin
      irq_stat_next[IRQ_ACK_BIT] = 1'b1;
    end
    if (wr_en && hit_mask) begin
      irq_mask_next = wbyte[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_reg <= IRQ_RESET;
      irq_mask_reg <= IRQ_RESET;
      tcf_prev_reg <= 1'b0;
      ack_prev_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      tcf_prev_reg <= tcf_prev_next;
      ack_prev_reg <= ack_prev_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // read data, captured during the setup cycle
  logic [DATA_W-1:0] prdata_reg, prdata_next;

  always_comb begin
    prdata_next = prdata_reg;
    if (setup_rd) begin
      prdata_next = '0;
      if (hit_scs) begin
        prdata_next[7:0] = {scs_reg[7:4], 4'h0};
      end else if (hit_ctrl) begin
        prdata_next[3:0] = {state_reg == WAIT_BYTE, stop_ack, ctrl_reg};
      end else if (hit_stat) begin
        prdata_next[1:0] = irq_stat_reg;
      end else if (hit_mask) begin
        prdata_next[1:0] = irq_mask_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence busy_req_s;
    state_reg == RUN && stop_req && scs_reg.hold_en && transfer_active && mod_en;
  endsequence

  sequence byte_end_s;
    state_reg == WAIT_BYTE && stop_req && byte_done;
  endsequence

  busy_defer_a: assert property (busy_req_s |=> !stop_ack ##0 state_reg == WAIT_BYTE)
    else $error("ack given before byte end");
  byte_end_ack_a: assert property (byte_end_s |=> stop_ack)
    else $error("no ack after byte end");
  idle_ack_a: assert property (state_reg == RUN && stop_req && scs_reg.hold_en &&
    (!transfer_active || !mod_en) |=> stop_ack)
    else $error("idle request not acked at once");
  no_hold_a: assert property (state_reg == RUN && stop_req && !scs_reg.hold_en |=> stop_ack)
    else $error("stop entry delayed without holdoff");
  ack_level_a: assert property (stop_ack && stop_req |=> stop_ack)
    else $error("ack dropped while request stands");
  tcf_irq_a: assert property (tcf_set |=> irq_stat_reg[IRQ_FLAG_BIT])
    else $error("completion not flagged");
  stop_flag_a: assert property (stop_det && slave_matched && !master_active |=> scs_reg.stop_flag)
    else $error("stop flag not set");
  master_stop_a: assert property (!scs_reg.stop_flag && master_active |=> !scs_reg.stop_flag)
    else $error("stop flag set for own master");
  start_flag_a: assert property (start_det |=> scs_reg.start_flag)
    else $error("start flag not set");
  cond_gate_a: assert property (!irq_stat_reg[IRQ_FLAG_BIT] && !scs_reg.cond_ie && !mod_ie
    |=> !irq_stat_reg[IRQ_FLAG_BIT])
    else $error("irq flag raised while disabled");
  reassert_a: assert property (cond_set |=> irq_stat_reg[IRQ_FLAG_BIT])
    else $error("irq flag not reasserted");
  rsvd_zero_a: assert property (setup_rd && hit_scs |=> prdata_reg[3:0] == 4'h0)
    else $error("reserved bits read nonzero");

  // the ack follows a withdrawn request down within one cycle, and a stop
  // seen by an unmatched device must leave the flag alone
  ack_drop_a: assert property (!stop_req |=> !stop_ack)
    else $error("ack held after request withdrawn");
  unmatched_stop_a: assert property (!scs_reg.stop_flag && !slave_matched |=> !scs_reg.stop_flag)
    else $error("stop flag set while unmatched");

endmodule

// *** hw/stophold_pkg.sv ***
/*
  Constants and types for the stop-holdoff and bus-condition block.
  Assumes a 200 MHz mclk and an APB master with 32-bit data.
*/
package stophold_pkg;

  // ==========================================================
  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] SCS_INDEX = 16'h18B6;
  localparam logic [ADDR_W-1:0] CTRL_INDEX = 16'h18C0;
  localparam logic [ADDR_W-1:0] IRQ_STAT_INDEX = 16'h18C1;
  localparam logic [ADDR_W-1:0] IRQ_MASK_INDEX = 16'h18C2;
  localparam logic [ADDR_W-1:0] SCS_ADDR = 16'h62D8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 16'h6300;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 16'h6304;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 16'h6308;

  // ==========================================================
  // field positions
  localparam int HOLD_EN_BIT = 7;
  localparam int STOP_FLAG_BIT = 6;
  localparam int COND_IE_BIT = 5;
  localparam int START_FLAG_BIT = 4;
  localparam int MOD_IE_BIT = 0;
  localparam int MOD_EN_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int WAIT_BIT = 3;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_ACK_BIT = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0] SCS_RESET = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // the stop-control/status register as carried in the design
  typedef struct packed {
    logic hold_en;
    logic stop_flag;
    logic cond_ie;
    logic start_flag;
    logic [3:0] rsvd;
  } scs_type;

  // apb request as one bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_type;

endpackage

// *** verification/bus_peer.sv ***
/*
  Model of the far side of the i2c bus: a peer making START and STOP.
  Assumes pull-ups on scl and sda and a 64 ns link period.
*/
module bus_peer (
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // idle: pull-ups hold both high, clock stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // ====================
  // start: free both lines first, since a frame left open holds them low;
  // then sda falls with scl high; offset keeps it off the mclk phase
  task automatic make_start();
    #7 sda <= 1'b1;
    #32 scl <= 1'b1;
    #32 sda <= 1'b0;
    #32 scl <= 1'b0;
  endtask
  // stop: sda low under a low clock, clock up, then sda rises
  task automatic make_stop();
    #7 sda <= 1'b0;
    #32 scl <= 1'b1;
    #32 sda <= 1'b1;
  endtask
endmodule

// *** verification/testbench.sv ***
/*
  Self-checking bench for the stop holdoff and bus condition block.
  Assumes the bus_peer model and the package are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import stophold_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  apb_req_type apb_req = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, scl, sda, stop_ack, irq, err;
  logic transfer_active = 1'b0;
  logic byte_done = 1'b0;
  logic slave_matched = 1'b0;
  logic master_active = 1'b0;
  logic tc_flag = 1'b0;
  logic stop_req = 1'b0;
  logic [31:0] rd;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // ====================
  // clock and instances
  always #2.5 mclk = ~mclk;
  i2c_stophold_busdetect dut (.mclk(mclk), .srst(srst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .sda_in(sda), .transfer_active(transfer_active), .byte_done(byte_done),
    .slave_matched(slave_matched), .master_active(master_active),
    .transfer_complete_flag(tc_flag), .stop_req(stop_req),
    .stop_ack(stop_ack), .irq(irq));
  bus_peer peer (.scl(scl), .sda(sda));
  // ====================
  // verdict and compare helpers
  task automatic wrap_up();
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string m);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, seen, want);
    end
  endtask
  // hang guard: far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  // ====================
  // apb master: request held until pready seen at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    apb_req <= '{1'b1, 1'b0, w, a, d, 4'hF};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
    #1;
  endtask
  // stop request as a level; ack looked at after the one-cycle answer
  task automatic req(input logic busy, input logic want);
    @(posedge mclk);
    transfer_active <= busy;
    stop_req <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(stop_ack, want, "ack");
  endtask
  task automatic unreq();
    @(posedge mclk);
    stop_req <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(stop_ack, 1'b0, "ack drop");
  endtask
  task automatic bus_frame(input logic with_stop);
    peer.make_start();
    if (with_stop) begin
      peer.make_stop();
    end
    repeat (10) @(posedge mclk);
  endtask
  // ====================
  // scenarios
  task automatic t_regs();
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'h0, "scs reset");
    apb(1'b1, SCS_ADDR, 32'hFF);
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'hA0, "scs rw");
    apb(1'b0, 16'h0010, 32'h0);
    chk(err, 1'b1, "unmapped");
  endtask
  task automatic t_start();
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    bus_frame(1'b0);
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'hB0, "start flag");
    chk(irq, 1'b1, "cond irq");
    apb(1'b1, IRQ_STAT_ADDR, 32'h1);
    apb(1'b0, IRQ_STAT_ADDR, 32'h0);
    chk(rd[0], 1'b1, "irq reasserts");
    apb(1'b1, SCS_ADDR, 32'hB0);
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'hA0, "start w1c");
    apb(1'b1, IRQ_STAT_ADDR, 32'h1);
    chk(irq, 1'b0, "irq cleared");
  endtask
  task automatic t_stop();
    apb(1'b1, SCS_ADDR, 32'h80);
    slave_matched <= 1'b1;
    bus_frame(1'b1);
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'hD0, "stop flag");
    chk(irq, 1'b0, "cond irq off");
    apb(1'b1, SCS_ADDR, 32'hD0);
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'h80, "stop w1c");
    master_active <= 1'b1;
    bus_frame(1'b1);
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'h90, "master no stop");
    apb(1'b1, SCS_ADDR, 32'h90);
    master_active <= 1'b0;
    slave_matched <= 1'b0;
    bus_frame(1'b1);
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'h90, "unmatched no stop");
    apb(1'b1, SCS_ADDR, 32'h90);
  endtask
  task automatic t_hold();
    apb(1'b1, CTRL_ADDR, 32'h2);
    req(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    #1 chk(stop_ack, 1'b0, "held");
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'hA, "waiting for byte");
    @(posedge mclk);
    byte_done <= 1'b1;
    @(posedge mclk);
    byte_done <= 1'b0;
    @(posedge mclk);
    #1 chk(stop_ack, 1'b1, "after byte");
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h6, "ack visible");
    unreq();
    req(1'b0, 1'b1);
    unreq();
    apb(1'b1, CTRL_ADDR, 32'h0);
    req(1'b1, 1'b1);
    unreq();
    apb(1'b1, CTRL_ADDR, 32'h2);
    apb(1'b1, SCS_ADDR, 32'h0);
    req(1'b1, 1'b1);
    unreq();
    // cut transfer restarted: the peer makes a fresh START, then a STOP
    bus_frame(1'b1);
    apb(1'b0, SCS_ADDR, 32'h0);
    chk(rd, 32'h10, "restart start");
    apb(1'b1, SCS_ADDR, 32'h10);
  endtask
  task automatic t_tc();
    apb(1'b0, IRQ_STAT_ADDR, 32'h0);
    chk(rd, 32'h2, "ack event");
    apb(1'b1, CTRL_ADDR, 32'h3);
    apb(1'b1, IRQ_STAT_ADDR, 32'h3);
    // completion lands while stop is acked and shows after wake-up
    req(1'b0, 1'b1);
    tc_flag <= 1'b1;
    unreq();
    chk(irq, 1'b1, "tc irq");
    apb(1'b1, IRQ_MASK_ADDR, 32'h0);
    chk(irq, 1'b0, "masked");
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    apb(1'b1, IRQ_STAT_ADDR, 32'h1);
    chk(irq, 1'b0, "tc cleared");
  endtask
  // ====================
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_start();
    t_stop();
    t_hold();
    t_tc();
    wrap_up();
  end
endmodule
